// >>> sso_pkg.sv
// Package of constants, types and register map for the servo status outputs
package sso_pkg;

  // ****************************************************************
  // Output assignment codes
  // ****************************************************************
  localparam logic [7:0] CODE_SPEED_REACHED = 8'h04;
  localparam logic [7:0] CODE_POS_REACHED = 8'h05;
  localparam logic [7:0] CODE_TORQUE_LIMIT = 8'h06;
  localparam logic [7:0] CODE_FAULT = 8'h07;
  localparam logic [7:0] CODE_BRAKE = 8'h08;
  localparam logic [7:0] CODE_OVL_WARN = 8'h10;
  localparam logic [7:0] CODE_WARNING = 8'h11;
  localparam int NUM_OUTS = 4;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TARGET_SPEED = 8'h04;
  localparam logic [7:0] ADDR_POS_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_OVL_PERMIT = 8'h0C;
  localparam logic [7:0] ADDR_OVL_PERCENT = 8'h10;
  localparam logic [7:0] ADDR_BRAKE_ON = 8'h14;
  localparam logic [7:0] ADDR_BRAKE_OFF = 8'h18;
  localparam logic [7:0] ADDR_ZERO_SPEED = 8'h1C;
  localparam logic [7:0] ADDR_ASSIGN = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h2C;
  localparam logic [7:0] ADDR_OVL_TIME = 8'h30;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_SERVO_ON = 0;
  localparam int CTRL_PULSE_MODE = 1;
  localparam int CTRL_TORQUE_MODE = 2;
  localparam int ST_SPEED = 0;
  localparam int ST_POS = 1;
  localparam int ST_TORQUE = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_BRAKE = 4;
  localparam int ST_OVL_WARN = 5;
  localparam int ST_WARNING = 6;
  localparam int ST_OVL_ALARM = 7;
  localparam int NUM_COND = 8;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic [15:0] RST_TARGET_SPEED = 16'h0BB8;
  localparam logic [15:0] RST_ZERO_SPEED = 16'h000A;
  localparam logic [6:0] RST_OVL_PERCENT = 7'h3C;
  localparam logic [31:0] RST_OVL_PERMIT = 32'h00001F40;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam logic [31:0] PERCENT_FULL = 32'h00000064;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [15:0] speed;
    logic [31:0] pos_error;
    logic torque_limit_hit;
    logic fault_other;
    logic fault_warnable;
    logic overloaded;
  } sso_meas_type;

  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
  } sso_apb_req_type;

endpackage : sso_pkg

// >>> sso_delay.sv
// Delay timer in millisecond ticks for brake timing
`timescale 1ns/1ps
module sso_delay (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic tick,
  input wire logic start,
  input wire logic [15:0] delay_ms,
  output logic done
);

  logic [15:0] cnt_q;
  logic run_q;
  logic done_q;
  wire expired = run_q && tick && (cnt_q + 16'h0001 >= delay_ms);

  always_ff @(posedge core_clk) begin
    if (reset || start) begin
      cnt_q <= 16'h0000;
      run_q <= start && !reset;
      done_q <= 1'b0;
    end else if (expired) begin
      run_q <= 1'b0;
      done_q <= 1'b1;
    end else if (run_q && tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Zero delay finishes at once
  assign done = done_q || (run_q && delay_ms == 16'h0000);

endmodule : sso_delay

// >>> sso_top.sv
// Status output logic of a servo drive with APB registers
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module sso_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sso_pkg::sso_meas_type meas,
  input wire logic fault_promote,
  output logic [sso_pkg::NUM_OUTS-1:0] status_out,
  output logic irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [2:0] ctrl_q;
  logic [15:0] target_speed_q;
  logic [31:0] pos_window_q;
  logic [31:0] ovl_permit_q;
  logic [6:0] ovl_percent_q;
  logic [15:0] brake_on_delay_q;
  logic [15:0] brake_off_delay_q;
  logic [15:0] zero_speed_q;
  logic [31:0] assign_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;
  logic [31:0] prdata_q;

  wire wr_en = psel && penable && pwrite;
  wire rd_en = psel && penable && !pwrite;
  wire hit_ctrl = paddr == sso_pkg::ADDR_CTRL;
  wire hit_target = paddr == sso_pkg::ADDR_TARGET_SPEED;
  wire hit_window = paddr == sso_pkg::ADDR_POS_WINDOW;
  wire hit_permit = paddr == sso_pkg::ADDR_OVL_PERMIT;
  wire hit_percent = paddr == sso_pkg::ADDR_OVL_PERCENT;
  wire hit_bon = paddr == sso_pkg::ADDR_BRAKE_ON;
  wire hit_boff = paddr == sso_pkg::ADDR_BRAKE_OFF;
  wire hit_zero = paddr == sso_pkg::ADDR_ZERO_SPEED;
  wire hit_assign = paddr == sso_pkg::ADDR_ASSIGN;
  wire hit_status = paddr == sso_pkg::ADDR_STATUS;
  wire hit_istat = paddr == sso_pkg::ADDR_IRQ_STAT;
  wire hit_imask = paddr == sso_pkg::ADDR_IRQ_MASK;
  wire hit_otime = paddr == sso_pkg::ADDR_OVL_TIME;
  wire hit_any = hit_ctrl || hit_target || hit_window || hit_permit || hit_percent
    || hit_bon || hit_boff || hit_zero || hit_assign || hit_status || hit_istat
    || hit_imask || hit_otime;

  wire servo_on_state = ctrl_q[sso_pkg::CTRL_SERVO_ON];
  wire pulse_position_mode = ctrl_q[sso_pkg::CTRL_PULSE_MODE];
  wire torque_mode = ctrl_q[sso_pkg::CTRL_TORQUE_MODE];

  // ****************************************************************
  // Write enables
  // ****************************************************************
  // Read-only STATUS and OVL_TIME get no enable, so writes to them are dropped
  wire wr_ctrl = wr_en && hit_ctrl;
  wire wr_target = wr_en && hit_target;
  wire wr_window = wr_en && hit_window;
  wire wr_permit = wr_en && hit_permit;
  wire wr_percent = wr_en && hit_percent;
  wire wr_bon = wr_en && hit_bon;
  wire wr_boff = wr_en && hit_boff;
  wire wr_zero = wr_en && hit_zero;
  wire wr_assign = wr_en && hit_assign;
  wire wr_istat = wr_en && hit_istat;
  wire wr_imask = wr_en && hit_imask;

  // ****************************************************************
  // Setting registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) ctrl_q <= 3'h0;
    else if (wr_ctrl) ctrl_q <= pwdata[2:0];
  end

  always_ff @(posedge core_clk) begin
    if (reset) target_speed_q <= sso_pkg::RST_TARGET_SPEED;
    else if (wr_target) target_speed_q <= pwdata[15:0];
  end

  always_ff @(posedge core_clk) begin
    if (reset) pos_window_q <= 32'h00000000;
    else if (wr_window) pos_window_q <= pwdata;
  end

  always_ff @(posedge core_clk) begin
    if (reset) ovl_permit_q <= sso_pkg::RST_OVL_PERMIT;
    else if (wr_permit) ovl_permit_q <= pwdata;
  end

  always_ff @(posedge core_clk) begin
    if (reset) ovl_percent_q <= sso_pkg::RST_OVL_PERCENT;
    else if (wr_percent) ovl_percent_q <= pwdata[6:0];
  end

  always_ff @(posedge core_clk) begin
    if (reset) brake_on_delay_q <= 16'h0000;
    else if (wr_bon) brake_on_delay_q <= pwdata[15:0];
  end

  always_ff @(posedge core_clk) begin
    if (reset) brake_off_delay_q <= 16'h0000;
    else if (wr_boff) brake_off_delay_q <= pwdata[15:0];
  end

  always_ff @(posedge core_clk) begin
    if (reset) zero_speed_q <= sso_pkg::RST_ZERO_SPEED;
    else if (wr_zero) zero_speed_q <= pwdata[15:0];
  end

  always_ff @(posedge core_clk) begin
    if (reset) assign_q <= 32'h00000000;
    else if (wr_assign) assign_q <= pwdata;
  end

  always_ff @(posedge core_clk) begin
    if (reset) irq_mask_q <= 8'h00;
    else if (wr_imask) irq_mask_q <= pwdata[7:0];
  end

  // ****************************************************************
  // Millisecond tick
  // ****************************************************************
  // Free-running: a brake delay may end up to one tick early
  logic [15:0] div_q;
  wire tick = div_q == 16'(sso_pkg::TICK_CYCLES - 1);

  always_ff @(posedge core_clk) begin
    if (reset || tick) div_q <= 16'h0000;
    else div_q <= div_q + 16'h0001;
  end

  // ****************************************************************
  // Speed, position and torque conditions
  // ****************************************************************
  logic speed_reached_q;
  wire speed_at_target = meas.speed >= target_speed_q;
  wire pos_in_window = pulse_position_mode && (meas.pos_error <= pos_window_q);
  wire torque_hit = meas.torque_limit_hit && !torque_mode;

  always_ff @(posedge core_clk) begin
    if (reset) speed_reached_q <= 1'b0;
    else speed_reached_q <= speed_at_target;
  end

  // ****************************************************************
  // Overload timing
  // ****************************************************************
  logic [31:0] ovl_time_q;
  // Product of two at most 32-bit operands; percent kept below 128
  wire [38:0] warn_scaled = 39'(ovl_permit_q) * 39'(ovl_percent_q);
  wire [38:0] warn_time = warn_scaled / 39'(sso_pkg::PERCENT_FULL);
  wire ovl_warn = 39'(ovl_time_q) > warn_time;
  wire ovl_alarm = ovl_time_q > ovl_permit_q;

  // Count resets once the overload stops: only continuous overload counts
  always_ff @(posedge core_clk) begin
    if (reset || !meas.overloaded) ovl_time_q <= 32'h00000000;
    else if (tick && ovl_time_q != 32'hFFFFFFFF) ovl_time_q <= ovl_time_q + 32'h00000001;
  end

  // ****************************************************************
  // Fault and warning
  // ****************************************************************
  logic warn_fault_q;
  wire warning = meas.fault_warnable;

  // Warnable faults reach the fault output only once promoted, a cycle later
  always_ff @(posedge core_clk) begin
    if (reset) warn_fault_q <= 1'b0;
    else warn_fault_q <= meas.fault_warnable && fault_promote;
  end

  wire fault = meas.fault_other || warn_fault_q || ovl_alarm;

  // ****************************************************************
  // Brake control
  // ****************************************************************
  typedef enum logic [1:0] {BRK_HELD, BRK_RELEASING, BRK_FREE, BRK_ENGAGING} sso_brk_type;
  sso_brk_type brk_q;
  sso_brk_type brk_d;
  logic son_prev_q;
  logic brake_q;
  logic on_done;
  logic off_done;
  wire son_rise = servo_on_state && !son_prev_q;
  wire son_fall = !servo_on_state && son_prev_q;
  wire at_zero_speed = meas.speed <= zero_speed_q;

  sso_delay u_on_delay (
    .core_clk(core_clk),
    .reset(reset),
    .tick(tick),
    .start(son_rise),
    .delay_ms(brake_on_delay_q),
    .done(on_done)
  );

  sso_delay u_off_delay (
    .core_clk(core_clk),
    .reset(reset),
    .tick(tick),
    .start(son_fall),
    .delay_ms(brake_off_delay_q),
    .done(off_done)
  );

  always_comb begin
    brk_d = brk_q;
    unique case (brk_q)
      BRK_HELD: begin
        if (son_rise) brk_d = BRK_RELEASING;
      end
      BRK_RELEASING: begin
        if (!servo_on_state) brk_d = BRK_HELD;
        else if (on_done) brk_d = BRK_FREE;
      end
      BRK_FREE: begin
        if (son_fall) brk_d = BRK_ENGAGING;
      end
      BRK_ENGAGING: begin
        if (servo_on_state) brk_d = BRK_RELEASING;
        else if (off_done || at_zero_speed) brk_d = BRK_HELD;
      end
    endcase
  end

  // Brake output high means brake released
  always_ff @(posedge core_clk) begin
    if (reset) begin
      brk_q <= BRK_HELD;
      son_prev_q <= 1'b0;
      brake_q <= 1'b0;
    end else begin
      brk_q <= brk_d;
      son_prev_q <= servo_on_state;
      brake_q <= (brk_d == BRK_FREE) || (brk_d == BRK_ENGAGING);
    end
  end

  // ****************************************************************
  // Condition vector, interrupts, output mapping
  // ****************************************************************
  logic [sso_pkg::NUM_COND-1:0] cond_q;
  logic [sso_pkg::NUM_COND-1:0] cond_prev_q;
  wire [sso_pkg::NUM_COND-1:0] cond_d = {ovl_alarm, warning, ovl_warn, brake_q, fault,
    torque_hit, pos_in_window, speed_reached_q};
  wire [sso_pkg::NUM_COND-1:0] cond_rise = cond_q & ~cond_prev_q;
  wire [sso_pkg::NUM_COND-1:0] irq_clr = wr_istat ? pwdata[7:0] : 8'h00;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cond_q <= 8'h00;
      cond_prev_q <= 8'h00;
      irq_stat_q <= 8'h00;
    end else begin
      cond_q <= cond_d;
      cond_prev_q <= cond_q;
      irq_stat_q <= (irq_stat_q & ~irq_clr) | cond_rise;
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  function automatic logic pick(input logic [7:0] code, input logic [7:0] c);
    unique case (code)
      sso_pkg::CODE_SPEED_REACHED: pick = c[sso_pkg::ST_SPEED];
      sso_pkg::CODE_POS_REACHED: pick = c[sso_pkg::ST_POS];
      sso_pkg::CODE_TORQUE_LIMIT: pick = c[sso_pkg::ST_TORQUE];
      sso_pkg::CODE_FAULT: pick = c[sso_pkg::ST_FAULT];
      sso_pkg::CODE_BRAKE: pick = c[sso_pkg::ST_BRAKE];
      sso_pkg::CODE_OVL_WARN: pick = c[sso_pkg::ST_OVL_WARN];
      sso_pkg::CODE_WARNING: pick = c[sso_pkg::ST_WARNING];
      default: pick = 1'b0;
    endcase
  endfunction : pick

  logic [sso_pkg::NUM_OUTS-1:0] out_q;
  genvar gi;
  generate
    for (gi = 0; gi < sso_pkg::NUM_OUTS; gi++) begin : g_out
      always_ff @(posedge core_clk) begin
        if (reset) out_q[gi] <= 1'b0;
        else out_q[gi] <= pick(assign_q[gi*8 +: 8], cond_q);
      end
    end
  endgenerate
  assign status_out = out_q;

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_ctrl) rd_mux = {29'h0, ctrl_q};
    if (hit_target) rd_mux = {16'h0000, target_speed_q};
    if (hit_window) rd_mux = pos_window_q;
    if (hit_permit) rd_mux = ovl_permit_q;
    if (hit_percent) rd_mux = {25'h0, ovl_percent_q};
    if (hit_bon) rd_mux = {16'h0000, brake_on_delay_q};
    if (hit_boff) rd_mux = {16'h0000, brake_off_delay_q};
    if (hit_zero) rd_mux = {16'h0000, zero_speed_q};
    if (hit_assign) rd_mux = assign_q;
    if (hit_status) rd_mux = {24'h000000, cond_q};
    if (hit_istat) rd_mux = {24'h000000, irq_stat_q};
    if (hit_imask) rd_mux = {24'h000000, irq_mask_q};
    if (hit_otime) rd_mux = ovl_time_q;
  end

  // Latched in setup so read data come from a register
  wire rd_setup = psel && !penable;
  always_ff @(posedge core_clk) begin
    if (reset) prdata_q <= 32'h00000000;
    else if (rd_setup) prdata_q <= rd_mux;
  end

  // One access cycle; read data latched in setup
  assign pready = 1'b1;
  // Unmapped access: error, write dropped, read data zero
  assign pslverr = psel && penable && !hit_any;
  assign prdata = rd_en ? prdata_q : 32'h00000000;

endmodule : sso_top

// >>> sso_ctrl_model.sv
// Controller-side model that stamps the first rise of each status output
`timescale 1ns/1ps
module sso_ctrl_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clr,
  input wire logic [3:0] status_out,
  output logic [3:0][15:0] stamp_q
);
  // ********************
  // Rise stamps
  // ********************
  logic [15:0] cyc_q;
  logic [3:0] prev_q;
  // Only the first rise counts, so a later glitch cannot hide the order
  always_ff @(posedge core_clk) begin
    cyc_q <= reset ? 16'h0000 : cyc_q + 16'h0001;
    prev_q <= status_out;
    for (int i = 0; i < 4; i++) begin
      if (reset || clr) begin
        stamp_q[i] <= 16'hFFFF;
      end else if (status_out[i] && !prev_q[i] && stamp_q[i] == 16'hFFFF) begin
        stamp_q[i] <= cyc_q;
      end
    end
  end
endmodule : sso_ctrl_model

// >>> sso_top_asserts.sv
// Concurrent checks on the status output block ports
`timescale 1ns/1ps
module sso_top_asserts (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sso_pkg::sso_meas_type meas,
  input wire logic fault_promote,
  input wire logic [3:0] status_out,
  input wire logic irq
);
  // ********************
  // Shadow of written settings
  // ********************
  logic [31:0] asg_q;
  logic [2:0] ctrl_q;
  logic [15:0] tgt_q;
  logic [15:0] zsp_q;
  logic [2:0] age_q;
  logic [7:0] b0, b1, b2, b3;
  logic wr_d;
  assign wr_d = psel && penable && pwrite && pready;
  assign {b3, b2, b1, b0} = asg_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      asg_q <= 32'h00000000;
      ctrl_q <= 3'h0;
      tgt_q <= sso_pkg::RST_TARGET_SPEED;
      zsp_q <= sso_pkg::RST_ZERO_SPEED;
    end else if (wr_d) begin
      case (paddr)
        sso_pkg::ADDR_ASSIGN: asg_q <= pwdata;
        sso_pkg::ADDR_CTRL: ctrl_q <= pwdata[2:0];
        sso_pkg::ADDR_TARGET_SPEED: tgt_q <= pwdata[15:0];
        sso_pkg::ADDR_ZERO_SPEED: zsp_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end
  // Age since last assignment write, so a remap is not taken for an event
  always_ff @(posedge core_clk) begin
    if (reset || (wr_d && paddr == sso_pkg::ADDR_ASSIGN)) begin
      age_q <= 3'h0;
    end else if (age_q != 3'h7) begin
      age_q <= age_q + 3'h1;
    end
  end
  // ********************
  // Properties
  // ********************
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_quiet;
    !(meas.fault_other || meas.overloaded)[*4];
  endsequence
  a_speed_on: assert property (
    (b0 == sso_pkg::CODE_SPEED_REACHED && meas.speed >= tgt_q)[*5] |-> status_out[0])
    else $error("speed output low at target");
  a_speed_off: assert property (
    (b0 == sso_pkg::CODE_SPEED_REACHED && meas.speed < tgt_q)[*5] |-> !status_out[0])
    else $error("speed output high below target");
  a_pos_mode: assert property (
    (b0 == sso_pkg::CODE_POS_REACHED && !ctrl_q[1])[*5] |-> !status_out[0])
    else $error("position output high outside pulse mode");
  a_torque_mode: assert property (
    (b1 == sso_pkg::CODE_TORQUE_LIMIT && ctrl_q[2])[*5] |-> !status_out[1])
    else $error("torque output high in torque mode");
  a_fault_any: assert property (
    (b2 == sso_pkg::CODE_FAULT && meas.fault_other)[*5] |-> status_out[2])
    else $error("fault output low during fault");
  a_warn_any: assert property (
    (b3 == sso_pkg::CODE_WARNING && meas.fault_warnable)[*5] |-> status_out[3])
    else $error("warning output low during warnable fault");
  a_warn_first: assert property (
    s_quiet ##0 (asg_q == 32'h11070605 && age_q == 3'h7 && $rose(status_out[2]))
    |-> $past(status_out[3]))
    else $error("fault output rose before warning");
  a_brake_zero: assert property (
    (b1 == sso_pkg::CODE_BRAKE && !ctrl_q[0] && meas.speed <= zsp_q)[*8] |-> !status_out[1])
    else $error("brake output high at zero speed when off");
  a_ovl_clear: assert property (
    (b2 == sso_pkg::CODE_OVL_WARN && !meas.overloaded)[*6] |-> !status_out[2])
    else $error("overload warning without overload");
endmodule : sso_top_asserts
bind sso_top sso_top_asserts sso_top_asserts_i (.core_clk(core_clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
  .fault_promote(fault_promote), .status_out(status_out), .irq(irq));

// >>> sso_top_test.sv
// Self-checking bench for the servo status output block
`timescale 1ns/1ps
module sso_top_test;
  // ********************
  // Signals and instances
  // ********************
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  sso_pkg::sso_meas_type meas = '0;
  logic fault_promote = 1'b0;
  logic [3:0] status_out;
  logic irq;
  logic clr = 1'b0;
  logic [3:0][15:0] stamp;
  logic [31:0] rdat;
  logic rerr;
  int fail_count = 0;
  int num_checks = 0;
  typedef struct packed {
    logic [2:0] ctrl;
    sso_pkg::sso_meas_type m;
    logic pr;
    logic [7:0] st;
  } sso_row_type;
  sso_row_type rows [8];
  sso_top sso_top_i (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .meas(meas), .fault_promote(fault_promote),
    .status_out(status_out), .irq(irq));
  sso_ctrl_model sso_ctrl_model_i (.core_clk(core_clk), .reset(reset), .clr(clr),
    .status_out(status_out), .stamp_q(stamp));
  always #25 core_clk = ~core_clk;
  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One idle cycle after each transfer keeps psel from being driven twice at one edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Only the watchdog ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : xfer
  task automatic wait_out(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (status_out[b] !== v && n < lim) begin
      n++;
      @(posedge core_clk);
    end
    if (status_out[b] !== v) fail_count++;
  endtask : wait_out
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // Overload waits span up to three 1 ms ticks
  initial begin
    repeat (95000) @(posedge core_clk);
    fail_count++;
    print_verdict();
  end
  // ********************
  // Sequence
  // ********************
  initial begin
    rows[0] = {3'h2, 16'h0BB8, 32'h00000064, 4'h0, 1'b0, 8'h03};
    rows[1] = {3'h2, 16'h0BB7, 32'h00000065, 4'h0, 1'b0, 8'h00};
    rows[2] = {3'h0, 16'h0000, 32'h00000005, 4'h0, 1'b0, 8'h00};
    rows[3] = {3'h0, 16'h0000, 32'h00000000, 4'h8, 1'b0, 8'h04};
    rows[4] = {3'h4, 16'h0000, 32'h00000000, 4'h8, 1'b0, 8'h00};
    rows[5] = {3'h0, 16'h0000, 32'h00000000, 4'h4, 1'b0, 8'h08};
    rows[6] = {3'h0, 16'h0000, 32'h00000000, 4'h2, 1'b0, 8'h40};
    rows[7] = {3'h0, 16'h0000, 32'h00000000, 4'h2, 1'b1, 8'h48};
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk({27'h0, irq, status_out}, 32'h0);
    xfer(1'b0, sso_pkg::ADDR_TARGET_SPEED, 32'h0);
    chk(rdat, 32'h00000BB8);
    chk({30'h0, pready, rerr}, 32'h2);
    chk(prdata, 32'h0);
    xfer(1'b1, sso_pkg::ADDR_POS_WINDOW, 32'h00000064);
    xfer(1'b1, sso_pkg::ADDR_ASSIGN, 32'h11070605);
    $display("reset test done");
    foreach (rows[i]) begin
      xfer(1'b1, sso_pkg::ADDR_CTRL, {29'h0, rows[i].ctrl});
      meas <= rows[i].m;
      fault_promote <= rows[i].pr;
      repeat (6) @(posedge core_clk);
      xfer(1'b0, sso_pkg::ADDR_STATUS, 32'h0);
      chk(rdat, {24'h0, rows[i].st});
      chk({28'h0, status_out}, {28'h0, rows[i].st[6], rows[i].st[3:1]});
      $display("row %0d done", i);
    end
    xfer(1'b1, 8'h3C, 32'hFFFFFFFF);
    chk({31'h0, rerr}, 32'h1);
    xfer(1'b1, sso_pkg::ADDR_IRQ_MASK, 32'h8);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, sso_pkg::ADDR_IRQ_STAT, 32'h8);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, sso_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    xfer(1'b0, sso_pkg::ADDR_STATUS, 32'h0);
    chk(rdat, 32'h00000048);
    xfer(1'b0, sso_pkg::ADDR_IRQ_STAT, 32'h0);
    chk(rdat, 32'h00000047);
    $display("bus and interrupt test done");
    meas <= '0;
    fault_promote <= 1'b0;
    clr <= 1'b1;
    repeat (6) @(posedge core_clk);
    clr <= 1'b0;
    meas <= 52'h2;
    fault_promote <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk({31'h0, stamp[3] < stamp[2]}, 32'h1);
    chk({28'h0, status_out}, 32'h0000000C);
    $display("warning order test done");
    xfer(1'b1, sso_pkg::ADDR_ASSIGN, 32'h07100804);
    xfer(1'b1, sso_pkg::ADDR_BRAKE_OFF, 32'h5);
    xfer(1'b1, sso_pkg::ADDR_BRAKE_ON, 32'h0);
    meas <= {16'h0100, 36'h000000000};
    xfer(1'b1, sso_pkg::ADDR_CTRL, 32'h1);
    wait_out(1, 1'b1, 50);
    chk({28'h0, status_out}, 32'h00000002);
    xfer(1'b1, sso_pkg::ADDR_CTRL, 32'h0);
    repeat (20) @(posedge core_clk);
    chk({31'h0, status_out[1]}, 32'h1);
    meas <= {16'h000A, 36'h000000000};
    wait_out(1, 1'b0, 20);
    chk({31'h0, status_out[1]}, 32'h0);
    $display("brake test done");
    xfer(1'b1, sso_pkg::ADDR_OVL_PERMIT, 32'h2);
    xfer(1'b1, sso_pkg::ADDR_OVL_PERCENT, 32'h32);
    meas <= {16'h0BB8, 36'h000000001};
    wait_out(2, 1'b1, 45000);
    xfer(1'b0, sso_pkg::ADDR_OVL_TIME, 32'h0);
    chk(rdat, 32'h2);
    chk({28'h0, status_out}, 32'h00000005);
    wait_out(3, 1'b1, 25000);
    xfer(1'b0, sso_pkg::ADDR_OVL_TIME, 32'h0);
    chk(rdat, 32'h3);
    xfer(1'b0, sso_pkg::ADDR_STATUS, 32'h0);
    chk(rdat, 32'h000000A9);
    meas <= {16'h0BB8, 36'h000000000};
    wait_out(2, 1'b0, 20);
    wait_out(3, 1'b0, 20);
    chk({28'h0, status_out}, 32'h1);
    $display("overload test done");
    print_verdict();
  end
endmodule : sso_top_test
